/* File: level_switch_pkg.sv */
/*
 * Shared constants of the level switch operator menu: timebase, hold times,
 * selector positions, key patterns, setting steps and reset values, register map.
 * Assumes a single 20 MHz clock and a synchronous active-high reset.
 */
package level_switch_pkg;

   // timebase
   localparam int CLK_HZ          = 20_000_000;
   localparam int TICK_MS         = 100;
   localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;

   // times in milliseconds
   localparam int HOLD_MS     = 2000;
   localparam int CALRST_MS   = 10000;
   localparam int FACTORY_MS  = 20000;
   localparam int BLINK_MS    = 5000;
   localparam int FLASH_MS    = 500;
   localparam int CONFIRM_MS  = 1000;
   localparam int DLY0_MS     = 300;
   localparam int DLY1_MS     = 1500;
   localparam int DLY2_MS     = 5000;
   localparam int DLY3_MS     = 10000;

   // times in ticks, least times rounded up
   localparam int TIME_W = 8;
   localparam logic [TIME_W-1:0] HOLD_TICKS    = TIME_W'((HOLD_MS + TICK_MS - 1) / TICK_MS);
   localparam logic [TIME_W-1:0] CALRST_TICKS  = TIME_W'((CALRST_MS + TICK_MS - 1) / TICK_MS);
   localparam logic [TIME_W-1:0] FACTORY_TICKS = TIME_W'((FACTORY_MS + TICK_MS - 1) / TICK_MS);
   localparam logic [TIME_W-1:0] BLINK_TICKS   = TIME_W'((BLINK_MS + TICK_MS - 1) / TICK_MS);
   localparam logic [TIME_W-1:0] FLASH_TICKS   = TIME_W'((FLASH_MS + TICK_MS - 1) / TICK_MS);
   localparam logic [TIME_W-1:0] CONFIRM_TICKS = TIME_W'((CONFIRM_MS + TICK_MS - 1) / TICK_MS);
   localparam logic [TIME_W-1:0] DLY0_TICKS    = TIME_W'((DLY0_MS + TICK_MS - 1) / TICK_MS);
   localparam logic [TIME_W-1:0] DLY1_TICKS    = TIME_W'((DLY1_MS + TICK_MS - 1) / TICK_MS);
   localparam logic [TIME_W-1:0] DLY2_TICKS    = TIME_W'((DLY2_MS + TICK_MS - 1) / TICK_MS);
   localparam logic [TIME_W-1:0] DLY3_TICKS    = TIME_W'((DLY3_MS + TICK_MS - 1) / TICK_MS);

   // function selector positions 1..8 encoded 0..7
   localparam int SEL_W = 3;
   localparam logic [SEL_W-1:0] POS_OPER     = 3'h0;
   localparam logic [SEL_W-1:0] POS_CAL      = 3'h1;
   localparam logic [SEL_W-1:0] POS_SP       = 3'h2;
   localparam logic [SEL_W-1:0] POS_RANGE    = 3'h3;
   localparam logic [SEL_W-1:0] POS_DELAY    = 3'h4;
   localparam logic [SEL_W-1:0] POS_SELFTEST = 3'h5;
   localparam logic [SEL_W-1:0] POS_FAILSAFE = 3'h6;
   localparam logic [SEL_W-1:0] POS_DATA     = 3'h7;

   // key patterns {plus, minus}
   localparam logic [1:0] KEY_NONE  = 2'h0;
   localparam logic [1:0] KEY_MINUS = 2'h1;
   localparam logic [1:0] KEY_PLUS  = 2'h2;
   localparam logic [1:0] KEY_BOTH  = 2'h3;

   // settings: switchpoint 2/4/8/16/32 pF, delay 0.3/1.5/5/10 s
   localparam int SP_IDX_W  = 3;
   localparam int DLY_IDX_W = 2;
   localparam logic [SP_IDX_W-1:0]  SP_RESET_IDX   = 3'h0;
   localparam logic [SP_IDX_W-1:0]  SP_MAX_IDX     = 3'h4;
   localparam logic [DLY_IDX_W-1:0] DLY_RESET_IDX  = 2'h1;
   localparam logic [DLY_IDX_W-1:0] DLY_MAX_IDX    = 2'h3;
   localparam logic RANGE_500      = 1'b0;
   localparam logic RANGE_1600     = 1'b1;
   localparam logic RANGE_RESET    = RANGE_500;
   localparam logic FAILSAFE_MIN   = 1'b0;
   localparam logic FAILSAFE_MAX   = 1'b1;
   localparam logic FAILSAFE_RESET = FAILSAFE_MAX;
   localparam logic SELFTEST_RESET = 1'b0;

   // indicators
   localparam int LED_W    = 6;
   localparam int LED_SW   = 5;
   localparam logic [4:0] LED_ALL5 = 5'h1F;

   // register map
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_SETTINGS = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_INT_STAT = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_CONTROL  = 8'h10;
   localparam int STATUS_USED   = 10;
   localparam int SETTINGS_USED = 8;

   // interrupt status bits and control register test bit
   localparam int INT_W       = 4;
   localparam int INT_ACCEPT  = 0;
   localparam int INT_REFUSED = 1;
   localparam int INT_SWITCH  = 2;
   localparam int INT_DAMAGE  = 3;
   localparam int CTRL_TEST   = 0;

   typedef enum logic [1:0] {LOOP_HIGH, LOOP_LOW, LOOP_FAULT, LOOP_OPEN} loop_t;

endpackage

/* File: key_hold_timer.sv */
/*
 * Key hold timer: counts timebase ticks while one key pattern stays pressed.
 * Assumes keys are synchronous to clk and tick is a one-cycle pulse.
 */
`timescale 1ns/1ps
module key_hold_timer
   import level_switch_pkg::*;
#(
   parameter int CNT_W = TIME_W
)
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // timebase and keys
   input  wire logic             tick,
   input  wire logic [1:0]       keys,
   // hold state
   output logic      [CNT_W-1:0] hold_ticks,
   output logic      [1:0]       hold_keys,
   output logic                  hold_adv
);

   // any change of the pattern restarts the count, so a late second key
   // does not inherit the time of the first one
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hold_keys  <= KEY_NONE;
         hold_ticks <= '0;
         hold_adv   <= 1'b0;
      end else if (keys != hold_keys) begin
         hold_keys  <= keys;
         hold_ticks <= '0;
         hold_adv   <= 1'b0;
      end else if (tick && keys != KEY_NONE && hold_ticks != '1) begin
         hold_ticks <= hold_ticks + 1'b1;
         hold_adv   <= 1'b1;
      end else begin
         hold_adv   <= 1'b0;
      end
   end

endmodule

/* File: level_switch_operator_menu.sv */
/*
 * Operator menu and loop output control of a capacitive point level switch:
 * selector and key decoding, settings, calibration flags, six indicators,
 * two-wire loop state, register port with sticky interrupts.
 * Assumes all inputs synchronous to the 20 MHz clk; keys are debounced outside.
 */
`timescale 1ns/1ps
// Function
// - loop drops from high to low current when the level limit is detected
// - test key held opens the loop output
// - sensor damage forces the fault level below 1 mA
// - green operational LED blinks once every five seconds
// - eight selector positions decoded, each except the data position (8) with at least one key function
// - lit LEDs and their meaning follow the selector position
// - key action taken only after a 2 s hold, then LEDs confirm it
// - switching LED follows output state under the selected fail-safe mode
// - switching LED flashes while no calibration exists
// - factory defaults: 2 pF, 500 pF, 1.5 s, self-test off, MAX mode
// - while safety-locked, settings changes are refused until unlocked
// - at first start output safe and switching LED flashes until calibrated
module level_switch_operator_menu
   import level_switch_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // operator controls
   input  wire logic [SEL_W-1:0]  selector,
   input  wire logic              key_minus,
   input  wire logic              key_plus,
   input  wire logic              test_key,
   // measurement
   input  wire logic              probe_covered,
   input  wire logic              sensor_damage,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   // outputs
   output logic      [LED_W-1:0]  led,
   output loop_t                  loop_state,
   output logic                   irq
);

   localparam int PRE_W = $clog2(TICK_CYCLES);

   logic [PRE_W-1:0]     pre_reg;
   logic                 tick_reg;
   logic [TIME_W-1:0]    hold_ticks;
   logic [1:0]           hold_keys;
   logic                 hold_adv;
   logic [SP_IDX_W-1:0]  sp_idx_reg;
   logic [DLY_IDX_W-1:0] dly_idx_reg;
   logic                 range_reg;
   logic                 selftest_reg;
   logic                 failsafe_reg;
   logic                 locked_reg;
   logic                 cal_empty_reg;
   logic                 cal_full_reg;
   logic                 calibrated;
   logic                 act_short;
   logic                 cal_clear_act;
   logic                 factory_act;
   logic                 unlock_act;
   logic                 change_req;
   logic                 refused;
   logic                 accepted;
   logic                 safe_raw;
   logic                 applied_reg;
   logic [TIME_W-1:0]    dcnt_reg;
   logic                 switch_now;
   logic [TIME_W-1:0]    blink_reg;
   logic [TIME_W-1:0]    flash_cnt_reg;
   logic                 flash_reg;
   logic [TIME_W-1:0]    confirm_reg;
   logic                 damage_d_reg;
   logic                 ctrl_test_reg;
   logic [INT_W-1:0]     int_stat_reg;
   logic [INT_W-1:0]     int_mask_reg;
   logic [INT_W-1:0]     events;
   logic [INT_W-1:0]     int_clr;
   loop_t                loop_next;
   logic [LED_W-1:0]     led_next;
   logic [DATA_W-1:0]    rdata_next;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   function automatic logic [4:0] onehot_led(input logic [SP_IDX_W-1:0] i);
      onehot_led = 5'h01 << i;
   endfunction

   function automatic logic [TIME_W-1:0] delay_ticks(input logic [DLY_IDX_W-1:0] i);
      unique case (i)
         2'h0: delay_ticks = DLY0_TICKS;
         2'h1: delay_ticks = DLY1_TICKS;
         2'h2: delay_ticks = DLY2_TICKS;
         2'h3: delay_ticks = DLY3_TICKS;
      endcase
   endfunction

   // tenth-second timebase; TICK_CYCLES must be at least 2
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pre_reg  <= '0;
         tick_reg <= 1'b0;
      end else if (pre_reg == PRE_W'(TICK_CYCLES - 1)) begin
         pre_reg  <= '0;
         tick_reg <= 1'b1;
      end else begin
         pre_reg  <= pre_reg + 1'b1;
         tick_reg <= 1'b0;
      end
   end

   key_hold_timer #(.CNT_W(TIME_W)) u_hold (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .tick       (tick_reg),
      .keys       ({key_plus, key_minus}),
      .hold_ticks (hold_ticks),
      .hold_keys  (hold_keys),
      .hold_adv   (hold_adv)
   );

   // action decode: short hold acts once, long holds act at their own mark
   always_comb begin
      act_short     = hold_adv && hold_ticks == HOLD_TICKS;
      cal_clear_act = hold_adv && hold_ticks == CALRST_TICKS && hold_keys == KEY_BOTH && selector == POS_CAL;
      factory_act   = hold_adv && hold_ticks == FACTORY_TICKS && hold_keys == KEY_BOTH && selector == POS_OPER;
      unlock_act    = act_short && hold_keys == KEY_BOTH && selector == POS_FAILSAFE;
      change_req    = (act_short && !unlock_act && selector != POS_OPER && selector != POS_DATA)
                      || cal_clear_act || factory_act;
      refused       = change_req && locked_reg;
      accepted      = (change_req && !locked_reg) || unlock_act;
      calibrated    = cal_empty_reg || cal_full_reg;
   end

   // settings; any change is blocked while locked
   always_ff @(posedge clk) begin
      if (sys_rst || (factory_act && !locked_reg)) begin
         sp_idx_reg   <= SP_RESET_IDX;
         dly_idx_reg  <= DLY_RESET_IDX;
         range_reg    <= RANGE_RESET;
         selftest_reg <= SELFTEST_RESET;
         failsafe_reg <= FAILSAFE_RESET;
      end else if (act_short && !locked_reg) begin
         unique case (selector)
            POS_SP: begin
               if (hold_keys == KEY_MINUS && sp_idx_reg != '0)
                  sp_idx_reg <= sp_idx_reg - 1'b1;
               else if (hold_keys == KEY_PLUS && sp_idx_reg != SP_MAX_IDX)
                  sp_idx_reg <= sp_idx_reg + 1'b1;
            end
            POS_RANGE: begin
               if (hold_keys == KEY_MINUS)
                  range_reg <= RANGE_1600;
               else if (hold_keys == KEY_PLUS)
                  range_reg <= RANGE_500;
            end
            POS_DELAY: begin
               if (hold_keys == KEY_MINUS && dly_idx_reg != '0)
                  dly_idx_reg <= dly_idx_reg - 1'b1;
               else if (hold_keys == KEY_PLUS && dly_idx_reg != DLY_MAX_IDX)
                  dly_idx_reg <= dly_idx_reg + 1'b1;
            end
            POS_SELFTEST: begin
               if (hold_keys == KEY_BOTH)
                  selftest_reg <= !selftest_reg;
            end
            POS_FAILSAFE: begin
               if (hold_keys == KEY_MINUS)
                  failsafe_reg <= FAILSAFE_MIN;
               else if (hold_keys == KEY_PLUS)
                  failsafe_reg <= FAILSAFE_MAX;
            end
            POS_OPER, POS_CAL, POS_DATA: begin
            end
         endcase
      end
   end

   // safety lock toggles only from the fail-safe position
   always_ff @(posedge clk) begin
      if (sys_rst)
         locked_reg <= 1'b0;
      else if (unlock_act)
         locked_reg <= !locked_reg;
   end

   // calibration points; the present probe state is the reference
   always_ff @(posedge clk) begin
      if (sys_rst || (!locked_reg && (cal_clear_act || factory_act))) begin
         cal_empty_reg <= 1'b0;
         cal_full_reg  <= 1'b0;
      end else if (act_short && !locked_reg && selector == POS_CAL) begin
         if (hold_keys == KEY_MINUS)
            cal_empty_reg <= 1'b1;
         else if (hold_keys == KEY_PLUS)
            cal_full_reg <= 1'b1;
      end
   end

   // limit: covered in MAX mode, uncovered in MIN mode, after the switching delay
   always_comb begin
      safe_raw   = (failsafe_reg == FAILSAFE_MAX) ? probe_covered : !probe_covered;
      switch_now = tick_reg && safe_raw != applied_reg && (dcnt_reg + 1'b1) >= delay_ticks(dly_idx_reg);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         applied_reg <= 1'b0;
         dcnt_reg    <= '0;
      end else if (safe_raw == applied_reg) begin
         dcnt_reg    <= '0;
      end else if (switch_now) begin
         applied_reg <= safe_raw;
         dcnt_reg    <= '0;
      end else if (tick_reg) begin
         dcnt_reg    <= dcnt_reg + 1'b1;
      end
   end

   // loop priority: open test, then fault, then safe low
   always_comb begin
      if (test_key || ctrl_test_reg)
         loop_next = LOOP_OPEN;
      else if (sensor_damage)
         loop_next = LOOP_FAULT;
      else if (!calibrated)
         loop_next = LOOP_LOW;
      else if (applied_reg)
         loop_next = LOOP_LOW;
      else
         loop_next = LOOP_HIGH;
   end

   // blink, flash and confirmation timers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         blink_reg     <= '0;
         flash_cnt_reg <= '0;
         flash_reg     <= 1'b0;
      end else if (tick_reg) begin
         blink_reg <= (blink_reg == BLINK_TICKS - 1'b1) ? '0 : blink_reg + 1'b1;
         if (flash_cnt_reg == FLASH_TICKS - 1'b1) begin
            flash_cnt_reg <= '0;
            flash_reg     <= !flash_reg;
         end else begin
            flash_cnt_reg <= flash_cnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst)
         confirm_reg <= '0;
      else if (!locked_reg && (cal_clear_act || factory_act))
         confirm_reg <= CONFIRM_TICKS;
      else if (tick_reg && confirm_reg != '0)
         confirm_reg <= confirm_reg - 1'b1;
   end

   // indicator pattern per selector position
   always_comb begin
      led_next = '0;
      if (!calibrated)
         led_next[LED_SW] = flash_reg;
      else
         led_next[LED_SW] = (loop_state == LOOP_HIGH);
      unique case (selector)
         POS_OPER:
            led_next[4:0] = {1'b0, locked_reg && failsafe_reg == FAILSAFE_MAX, sensor_damage && flash_reg,
                             locked_reg && failsafe_reg == FAILSAFE_MIN, blink_reg == '0};
         POS_CAL:
            led_next[4:0] = {cal_full_reg, 3'h0, cal_empty_reg};
         POS_SP:
            led_next[4:0] = onehot_led(sp_idx_reg);
         POS_RANGE:
            led_next[4:0] = {3'h0, range_reg == RANGE_1600, range_reg == RANGE_500};
         POS_DELAY:
            led_next[4:0] = onehot_led({1'b0, dly_idx_reg});
         POS_SELFTEST:
            led_next[4:0] = {selftest_reg && flash_reg, 4'h0};
         POS_FAILSAFE:
            led_next[4:0] = {failsafe_reg == FAILSAFE_MAX, locked_reg && failsafe_reg == FAILSAFE_MAX,
                             1'b0, locked_reg && failsafe_reg == FAILSAFE_MIN, failsafe_reg == FAILSAFE_MIN};
         POS_DATA:
            led_next[4:0] = 5'h00;
      endcase
      if (confirm_reg != '0)
         led_next[4:0] = LED_ALL5;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         led        <= '0;
         loop_state <= LOOP_LOW;
      end else begin
         led        <= led_next;
         loop_state <= loop_next;
      end
   end

   // interrupt events; a new event wins over a same-cycle clear
   always_comb begin
      events              = '0;
      events[INT_ACCEPT]  = accepted;
      events[INT_REFUSED] = refused;
      events[INT_SWITCH]  = switch_now;
      events[INT_DAMAGE]  = sensor_damage && !damage_d_reg;
      int_clr             = (reg_wr && reg_addr == ADDR_INT_STAT) ? reg_wdata[INT_W-1:0] : '0;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         int_stat_reg <= '0;
         damage_d_reg <= 1'b0;
         irq          <= 1'b0;
      end else begin
         int_stat_reg <= (int_stat_reg & ~int_clr) | events;
         damage_d_reg <= sensor_damage;
         irq          <= |(int_stat_reg & int_mask_reg);
      end
   end

   // register writes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         int_mask_reg  <= '0;
         ctrl_test_reg <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == ADDR_INT_MASK)
            int_mask_reg <= reg_wdata[INT_W-1:0];
         if (reg_addr == ADDR_CONTROL)
            ctrl_test_reg <= reg_wdata[CTRL_TEST];
      end
   end

   // register reads, unmapped addresses read zero
   always_comb begin
      rdata_next = '0;
      unique case (reg_addr)
         ADDR_STATUS:
            rdata_next = {(DATA_W - STATUS_USED)'(0), cal_full_reg, cal_empty_reg, selector,
                          applied_reg, locked_reg, calibrated, loop_state};
         ADDR_SETTINGS:
            rdata_next = {(DATA_W - SETTINGS_USED)'(0), failsafe_reg, selftest_reg, range_reg,
                          dly_idx_reg, sp_idx_reg};
         ADDR_INT_STAT: rdata_next = {(DATA_W - INT_W)'(0), int_stat_reg};
         ADDR_INT_MASK: rdata_next = {(DATA_W - INT_W)'(0), int_mask_reg};
         ADDR_CONTROL:  rdata_next = {(DATA_W - 1)'(0), ctrl_test_reg};
         default:       rdata_next = '0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst)
         reg_rdata <= '0;
      else
         reg_rdata <= reg_rd ? rdata_next : '0;
   end

   sequence both_held_factory;
      hold_keys == KEY_BOTH && selector == POS_OPER && factory_act && !locked_reg;
   endsequence

   sequence settings_restored;
      sp_idx_reg == SP_RESET_IDX && dly_idx_reg == DLY_RESET_IDX && range_reg == RANGE_RESET
      && failsafe_reg == FAILSAFE_RESET && !cal_empty_reg && !cal_full_reg;
   endsequence

   test_opens_loop_a: assert property (test_key |=> loop_state == LOOP_OPEN)
      else $error("test key did not open the loop");
   damage_fault_a: assert property (!test_key && !ctrl_test_reg && sensor_damage |=> loop_state == LOOP_FAULT)
      else $error("sensor damage did not force fault level");
   limit_low_a: assert property (!test_key && !ctrl_test_reg && !sensor_damage && calibrated && applied_reg
                                 |=> loop_state == LOOP_LOW)
      else $error("limit detected but loop not low");
   uncal_safe_a: assert property (!test_key && !ctrl_test_reg && !sensor_damage && !calibrated
                                  |=> loop_state == LOOP_LOW)
      else $error("uncalibrated output not in safe state");
   blink_gap_a: assert property (selector == POS_OPER && confirm_reg == '0 && blink_reg != '0 |=> !led[0])
      else $error("operational LED lit outside its blink");
   uncal_flash_a: assert property (!calibrated |=> led[LED_SW] == $past(flash_reg))
      else $error("switching LED not flashing while uncalibrated");
   sp_led_a: assert property (selector == POS_SP && confirm_reg == '0 |=> led[4:0] == onehot_led($past(sp_idx_reg)))
      else $error("switchpoint LEDs do not show the setting");
   sp_needs_hold_a: assert property ($changed(sp_idx_reg) && !$past(factory_act) |-> $past(act_short))
      else $error("switchpoint changed without a 2 s hold");
   sp_step_up_a: assert property (act_short && selector == POS_SP && hold_keys == KEY_PLUS && !locked_reg
                                  && sp_idx_reg != SP_MAX_IDX |=> sp_idx_reg == $past(sp_idx_reg) + 1'b1)
      else $error("plus key did not step switchpoint up");
   locked_refuse_a: assert property (locked_reg && change_req |=> $stable(sp_idx_reg) && $stable(dly_idx_reg)
                                     && $stable(failsafe_reg) && $stable(range_reg))
      else $error("setting changed while locked");
   factory_restore_a: assert property (both_held_factory |=> settings_restored)
      else $error("factory restore incomplete");
   reset_defaults_a: assert property ($fell(sys_rst) |-> settings_restored)
      else $error("defaults wrong after reset");

endmodule

/* File: isolating_amp_model.sv */
/* Isolating amplifier model on the two-wire loop: turns the loop state into
   break and alarm readings. Assumes loop_state is sampled on clk. */
`timescale 1ns/1ps
module isolating_amp_model
   import level_switch_pkg::*;
(
   // clock
   input  wire logic  clk,
   // loop
   input  wire loop_t loop_state,
   // readings
   output logic       line_break,
   output logic       line_alarm
);
   // readings are raw; a polling user must not poll faster than every 3 s
   always_ff @(posedge clk) begin
      line_break <= (loop_state == LOOP_OPEN);
      line_alarm <= (loop_state == LOOP_FAULT);
   end
endmodule

/* File: level_switch_operator_menu_bench.sv */
/* Bench of the operator menu: key holds, loop states, registers, interrupt.
   Assumes TICK_CYCLES of 4, so one tick is four clocks. */
`timescale 1ns/1ps
module level_switch_operator_menu_bench;
   import level_switch_pkg::*;
   logic              clk = 1'b0, sys_rst = 1'b1, key_minus = 1'b0, key_plus = 1'b0, test_key = 1'b0;
   logic              probe_covered = 1'b0, sensor_damage = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [SEL_W-1:0]  selector = POS_OPER;
   logic [ADDR_W-1:0] reg_addr = 8'h00;
   logic [DATA_W-1:0] reg_wdata = 32'h0, reg_rdata, rd;
   logic [LED_W-1:0]  led;
   loop_t             loop_state;
   logic              irq, line_break, line_alarm;
   int                error_cnt = 0, checks = 0, cyc = 0;
   level_switch_operator_menu #(.TICK_CYCLES(4)) u_level_switch_operator_menu (.clk(clk), .sys_rst(sys_rst),
      .selector(selector), .key_minus(key_minus), .key_plus(key_plus), .test_key(test_key),
      .probe_covered(probe_covered), .sensor_damage(sensor_damage), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .led(led), .loop_state(loop_state), .irq(irq));
   isolating_amp_model u_isolating_amp_model (.clk(clk), .loop_state(loop_state), .line_break(line_break),
      .line_alarm(line_alarm));
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic tally_and_finish();
      if (error_cnt == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   task automatic check(string what, logic [DATA_W-1:0] seen, logic [DATA_W-1:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rdr(logic [ADDR_W-1:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask
   // holds a key pattern for whole ticks, then releases and lets the menu settle
   task automatic hold(logic [SEL_W-1:0] pos, logic [1:0] keys, int ticks);
      @(posedge clk);
      selector <= pos;
      {key_plus, key_minus} <= keys;
      repeat (ticks * 4) @(posedge clk);
      // let go a few ticks after the confirming LED change
      {key_plus, key_minus} <= KEY_NONE;
      repeat (8) @(posedge clk);
   endtask
   task automatic s_defaults();
      check("loop", 32'(loop_state), 32'(LOOP_LOW));
      rdr(ADDR_SETTINGS);
      check("settings", rd, 32'h88);
      rdr(8'h40);
      check("unmapped", rd, 32'h0);
   endtask
   task automatic s_steps();
      hold(POS_SP, KEY_PLUS, 18);
      rdr(ADDR_SETTINGS);
      check("short hold", rd, 32'h88);
      hold(POS_SP, KEY_PLUS, 24);
      rdr(ADDR_SETTINGS);
      check("sp up", rd, 32'h89);
      check("sp leds", 32'(led[4:0]), 32'h02);
      hold(POS_DELAY, KEY_MINUS, 24);
      rdr(ADDR_SETTINGS);
      check("dly down", rd, 32'h81);
   endtask
   task automatic s_loop();
      hold(POS_CAL, KEY_PLUS, 24);
      selector <= POS_OPER;
      repeat (4) @(posedge clk);
      check("uncovered", 32'(loop_state), 32'(LOOP_HIGH));
      probe_covered <= 1'b1;
      repeat (8) @(posedge clk);
      check("delay", 32'(loop_state), 32'(LOOP_HIGH));
      repeat (30) @(posedge clk);
      check("covered", 32'(loop_state), 32'(LOOP_LOW));
      test_key <= 1'b1;
      repeat (3) @(posedge clk);
      check("test", {loop_state, line_break}, {LOOP_OPEN, 1'b1});
      test_key <= 1'b0;
      sensor_damage <= 1'b1;
      repeat (3) @(posedge clk);
      check("damage", {loop_state, line_alarm}, {LOOP_FAULT, 1'b1});
   endtask
   task automatic s_factory();
      hold(POS_OPER, KEY_BOTH, 204);
      check("factory leds", 32'(led[4:0]), 32'(LED_ALL5));
      rdr(ADDR_SETTINGS);
      check("factory", rd, 32'h88);
      rdr(ADDR_STATUS);
      check("factory cal", rd, 32'h12);
   endtask
   task automatic s_irq_lock();
      wr(ADDR_INT_MASK, 32'h8);
      repeat (2) @(posedge clk);
      check("irq set", 32'(irq), 32'h1);
      wr(ADDR_INT_STAT, 32'hF);
      repeat (2) @(posedge clk);
      check("irq clr", 32'(irq), 32'h0);
      hold(POS_FAILSAFE, KEY_BOTH, 24);
      hold(POS_SP, KEY_PLUS, 24);
      rdr(ADDR_SETTINGS);
      check("locked", rd, 32'h88);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1 s_defaults();
      s_steps();
      s_loop();
      s_factory();
      s_irq_lock();
      tally_and_finish();
   end
endmodule
